// [rtl/sbs_pkg.sv]
// Package of constants and types for the status byte and service request block.
package sbs_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int unsigned SBS_W = 8;

  // ---------------------------------------------------------------------------
  // Standard event flag bit positions
  // ---------------------------------------------------------------------------
  localparam int unsigned SBS_ESR_OPC = 0;
  localparam int unsigned SBS_ESR_RQC = 1;
  localparam int unsigned SBS_ESR_QYE = 2;
  localparam int unsigned SBS_ESR_DDE = 3;
  localparam int unsigned SBS_ESR_EXE = 4;
  localparam int unsigned SBS_ESR_CME = 5;
  localparam int unsigned SBS_ESR_URQ = 6;
  localparam int unsigned SBS_ESR_PON = 7;

  // ---------------------------------------------------------------------------
  // Summary status byte bit positions
  // ---------------------------------------------------------------------------
  localparam int unsigned SBS_STB_HW1 = 0;
  localparam int unsigned SBS_STB_HW2 = 1;
  localparam int unsigned SBS_STB_NU2 = 2;
  localparam int unsigned SBS_STB_QUE = 3;
  localparam int unsigned SBS_STB_MAV = 4;
  localparam int unsigned SBS_STB_ESB = 5;
  localparam int unsigned SBS_STB_RQS = 6;
  localparam int unsigned SBS_STB_OPR = 7;

  // ---------------------------------------------------------------------------
  // Masks and reset values
  // ---------------------------------------------------------------------------
  localparam logic [SBS_W-1:0] SBS_MSS_MASK  = 8'hbf;
  localparam logic [SBS_W-1:0] SBS_SRE_WMASK = 8'hbf;
  localparam logic [SBS_W-1:0] SBS_ESR_SMASK = 8'hbe;
  localparam logic [SBS_W-1:0] SBS_ESR_RST   = 8'h00;
  localparam logic [SBS_W-1:0] SBS_ESE_RST   = 8'h00;
  localparam logic [SBS_W-1:0] SBS_SRE_RST   = 8'h00;
  localparam logic [SBS_W-1:0] SBS_STB_RST   = 8'h00;
  localparam logic [SBS_W-1:0] SBS_ZERO      = 8'h00;

  // ---------------------------------------------------------------------------
  // Operation-complete tracking states
  // ---------------------------------------------------------------------------
  typedef enum logic [0:0] {
    SBS_OPC_IDLE = 1'b0,
    SBS_OPC_WAIT = 1'b1
  } sbs_opc_e;

endpackage

// [rtl/sbs_sticky_reg.sv]
// Sticky event register: per-bit set, whole-register clear, set wins over clear.
`timescale 1ns/1ps
module sbs_sticky_reg #(
  parameter int unsigned     W   = 8,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set,
  input  wire logic         clr,
  output logic      [W-1:0] q
);

  // ---------------------------------------------------------------------------
  // Per-bit storage
  // ---------------------------------------------------------------------------
  // An event landing in the same cycle as a read-clear must survive, so the
  // set term is given priority over the clear.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        q[i] <= RST[i];
      end else if (set[i]) begin
        q[i] <= 1'b1;
      end else if (clr) begin
        q[i] <= 1'b0;
      end
    end
  end

endmodule

// [rtl/sbs_status_top.sv]
// Status byte, standard event and service request logic of the instrument.
//
// Overview of operation
// - Operation-complete flag sets only after the OPC command and all pending work idle.
// - Standard event flags clear when queried and on the clear-status command.
// - Controller reads event flags, reads and writes the event enable register.
// - Writing zero to the event enable register is its only clear.
// - An 8-bit status byte summarises register groups and the output queue.
// - An 8-bit service request mask enables status byte bits as request causes.
// - Each summary bit is true when any enabled event in its groups is true.
// - Bits: 7 operation, 5 standard event, 4 message ready, 3 questionable, 1-0 hardware.
// - Serial poll reports bit 6 as the request-service state.
// - Serial poll clears request-service; other bits untouched.
// - Status query bit 6 is master summary: OR of status byte AND mask, bit 6 excluded.
// - Bit 6 meaning follows access method and no enable bit masks it.
// - The status query changes no status byte bit.
// - Status query answer is the byte with master summary weighted 64, 0 to 255.
// - Status byte is read-only and follows only the summary inputs.
// - Clear-status clears all event registers and groups, but not the message-ready summary.
// - Event flags: 7 power-on, 5 command, 4 execution, 3 device, 2 query errors, 1 control.
// - Bit 6 of any value written to the service request mask is dropped.
`timescale 1ns/1ps
module sbs_status_top
  import sbs_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      cmd_opc,
  input  wire logic                      ops_idle,
  input  wire logic                      cmd_cls,
  input  wire logic                      cmd_esr_rd,
  input  wire logic                      cmd_ese_rd,
  input  wire logic                      cmd_ese_wr,
  input  wire logic                      cmd_sre_rd,
  input  wire logic                      cmd_sre_wr,
  input  wire logic                      cmd_stb_rd,
  input  wire logic                      spoll_rd,
  input  wire logic [sbs_pkg::SBS_W-1:0] wr_data,
  input  wire logic [sbs_pkg::SBS_W-1:0] evt_set,
  input  wire logic                      sum_oper,
  input  wire logic                      sum_ques,
  input  wire logic                      sum_hw2,
  input  wire logic                      sum_hw1,
  input  wire logic                      mav,
  output logic                           rsp_valid_q,
  output logic      [sbs_pkg::SBS_W-1:0] rsp_data_q,
  output logic                           spoll_valid_q,
  output logic      [sbs_pkg::SBS_W-1:0] spoll_data_q,
  output logic                           srq_q,
  output logic                           grp_clr_q
);
  import sbs_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [SBS_W-1:0] esr_q;
  logic [SBS_W-1:0] esr_set;
  logic             esr_clr;
  logic [SBS_W-1:0] ese_q;
  logic [SBS_W-1:0] sre_q;
  logic [SBS_W-1:0] stb_d;
  logic [SBS_W-1:0] stb_q;
  logic             esb;
  logic             mss;
  logic             mss_prev_q;
  logic             mss_rise;
  logic             rqs_q;
  logic             por_pend_q;
  logic             opc_done;
  sbs_opc_e         opc_st_q;

  // ---------------------------------------------------------------------------
  // Operation-complete tracking
  // ---------------------------------------------------------------------------
  // Clear-status abandons a pending wait, so a stale request cannot later set
  // the flag after software has wiped the register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opc_st_q <= SBS_OPC_IDLE;
    end else if (cmd_cls) begin
      opc_st_q <= SBS_OPC_IDLE;
    end else begin
      unique case (opc_st_q)
        SBS_OPC_IDLE: begin
          if (cmd_opc) begin
            opc_st_q <= SBS_OPC_WAIT;
          end
        end
        SBS_OPC_WAIT: begin
          if (ops_idle) begin
            opc_st_q <= SBS_OPC_IDLE;
          end
        end
      endcase
    end
  end

  assign opc_done = (opc_st_q == SBS_OPC_WAIT) && ops_idle && !cmd_cls;

  // ---------------------------------------------------------------------------
  // Power-on flag
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_pend_q <= 1'b1;
    end else begin
      por_pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Standard event flags
  // ---------------------------------------------------------------------------
  always_comb begin
    esr_set              = evt_set & SBS_ESR_SMASK;
    esr_set[SBS_ESR_OPC] = opc_done;
    esr_set[SBS_ESR_PON] = evt_set[SBS_ESR_PON] | por_pend_q;
    esr_set[SBS_ESR_URQ] = 1'b0;
  end

  assign esr_clr = cmd_esr_rd | cmd_cls;

  sbs_sticky_reg #(
    .W   (SBS_W),
    .RST (SBS_ESR_RST)
  ) u_esr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .set     (esr_set),
    .clr     (esr_clr),
    .q       (esr_q)
  );

  // ---------------------------------------------------------------------------
  // Enable and mask registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ese_q <= SBS_ESE_RST;
    end else if (cmd_ese_wr) begin
      ese_q <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sre_q <= SBS_SRE_RST;
    end else if (cmd_sre_wr) begin
      sre_q <= wr_data & SBS_SRE_WMASK;
    end
  end

  // ---------------------------------------------------------------------------
  // Status byte
  // ---------------------------------------------------------------------------
  // The byte is rebuilt from the summaries every cycle; nothing writes it.
  assign esb = |(esr_q & ese_q);

  always_comb begin
    stb_d              = SBS_ZERO;
    stb_d[SBS_STB_OPR] = sum_oper;
    stb_d[SBS_STB_ESB] = esb;
    stb_d[SBS_STB_MAV] = mav;
    stb_d[SBS_STB_QUE] = sum_ques;
    stb_d[SBS_STB_HW2] = sum_hw2;
    stb_d[SBS_STB_HW1] = sum_hw1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stb_q <= SBS_STB_RST;
    end else begin
      stb_q <= stb_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Master summary and request service
  // ---------------------------------------------------------------------------
  // Bit 6 is excluded from the product, so no mask bit can gate it.
  assign mss      = |(stb_q & sre_q & SBS_MSS_MASK);
  assign mss_rise = mss && !mss_prev_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mss_prev_q <= 1'b0;
    end else begin
      mss_prev_q <= mss;
    end
  end

  // A fresh reason for service in the poll cycle wins over the poll's clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rqs_q <= 1'b0;
    end else if (mss_rise) begin
      rqs_q <= 1'b1;
    end else if (spoll_rd || !mss) begin
      rqs_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      srq_q <= 1'b0;
    end else begin
      srq_q <= mss_rise || (rqs_q && mss && !spoll_rd);
    end
  end

  // ---------------------------------------------------------------------------
  // Serial poll answer
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      spoll_valid_q <= 1'b0;
      spoll_data_q  <= SBS_ZERO;
    end else begin
      spoll_valid_q <= spoll_rd;
      if (spoll_rd) begin
        spoll_data_q              <= stb_q;
        spoll_data_q[SBS_STB_RQS] <= rqs_q;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Query answers
  // ---------------------------------------------------------------------------
  // One query per cycle is expected; if several collide the order below picks.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= SBS_ZERO;
    end else begin
      rsp_valid_q <= cmd_esr_rd | cmd_ese_rd | cmd_sre_rd | cmd_stb_rd;
      if (cmd_esr_rd) begin
        rsp_data_q <= esr_q;
      end else if (cmd_ese_rd) begin
        rsp_data_q <= ese_q;
      end else if (cmd_sre_rd) begin
        rsp_data_q <= sre_q;
      end else if (cmd_stb_rd) begin
        rsp_data_q              <= stb_q;
        rsp_data_q[SBS_STB_RQS] <= mss;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Group clear strobe
  // ---------------------------------------------------------------------------
  // The outside groups clear their own event registers on this pulse; the
  // output queue must not listen to it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      grp_clr_q <= 1'b0;
    end else begin
      grp_clr_q <= cmd_cls;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_opc_cause;
    $rose(esr_q[SBS_ESR_OPC]) |-> $past(opc_st_q == SBS_OPC_WAIT) && $past(ops_idle);
  endproperty
  a_opc_cause: assert property (p_opc_cause) else $error("opc flag set without completion");

  property p_opc_seq;
    (opc_st_q == SBS_OPC_IDLE) && cmd_opc && !cmd_cls ##1 ops_idle && !cmd_cls
      |=> esr_q[SBS_ESR_OPC];
  endproperty
  a_opc_seq: assert property (p_opc_seq) else $error("opc flag missing after idle");

  property p_esr_clear;
    (cmd_esr_rd || cmd_cls) && (esr_set == SBS_ZERO) |=> esr_q == SBS_ZERO;
  endproperty
  a_esr_clear: assert property (p_esr_clear) else $error("event flags not cleared");

  property p_esr_read;
    cmd_esr_rd |=> rsp_valid_q && (rsp_data_q == $past(esr_q));
  endproperty
  a_esr_read: assert property (p_esr_read) else $error("event flag query wrong");

  property p_ese_write;
    cmd_ese_wr |=> ese_q == $past(wr_data) ##1 ($past(cmd_ese_wr) || $stable(ese_q));
  endproperty
  a_ese_write: assert property (p_ese_write) else $error("event enable write lost");

  property p_stb_map;
    stb_q[SBS_STB_NU2] == 1'b0 && stb_q[SBS_STB_RQS] == 1'b0 &&
      stb_q[SBS_STB_MAV] == $past(mav) && stb_q[SBS_STB_ESB] == $past(|(esr_q & ese_q));
  endproperty
  a_stb_map: assert property (p_stb_map) else $error("status byte layout wrong");

  property p_sre_b6;
    cmd_sre_wr |=> sre_q[SBS_STB_RQS] == 1'b0 && sre_q[5:0] == $past(wr_data[5:0]);
  endproperty
  a_sre_b6: assert property (p_sre_b6) else $error("mask bit 6 stored");

  property p_poll_clear;
    spoll_rd && !mss_rise |=> !rqs_q ##1 (mss_rise || !spoll_data_q[SBS_STB_RQS] || !spoll_valid_q);
  endproperty
  a_poll_clear: assert property (p_poll_clear) else $error("poll left rqs set");

  property p_poll_data;
    spoll_rd |=> spoll_valid_q && spoll_data_q[SBS_STB_RQS] == $past(rqs_q) &&
      spoll_data_q[5:0] == $past(stb_q[5:0]) && spoll_data_q[7] == $past(stb_q[7]);
  endproperty
  a_poll_data: assert property (p_poll_data) else $error("poll byte wrong");

  property p_stb_query;
    cmd_stb_rd && !cmd_esr_rd && !cmd_ese_rd && !cmd_sre_rd |=>
      rsp_data_q[SBS_STB_RQS] == $past(|(stb_q & sre_q & SBS_MSS_MASK)) &&
      rsp_data_q[5:0] == $past(stb_q[5:0]);
  endproperty
  a_stb_query: assert property (p_stb_query) else $error("status query wrong");

  property p_stb_noside;
    cmd_stb_rd && !spoll_rd && !mss_rise && mss |=> rqs_q == $past(rqs_q);
  endproperty
  a_stb_noside: assert property (p_stb_noside) else $error("status query changed rqs");

  property p_srq;
    srq_q |-> $past(mss) && !$past(spoll_rd && !mss_rise);
  endproperty
  a_srq: assert property (p_srq) else $error("service request without cause");

  property p_cls;
    cmd_cls && (esr_set == SBS_ZERO) |=> grp_clr_q && esr_q == SBS_ZERO && opc_st_q == SBS_OPC_IDLE;
  endproperty
  a_cls: assert property (p_cls) else $error("clear-status incomplete");

  c_poll_after_srq: cover property (srq_q ##[1:8] spoll_rd ##1 !rqs_q);
  c_opc_done:       cover property (cmd_opc ##[1:20] esr_q[SBS_ESR_OPC]);
  c_stb_query_mss:  cover property (cmd_stb_rd && mss);
  c_cls_evt:        cover property (cmd_cls && esr_q != SBS_ZERO);

endmodule

// [tb/sbs_groups_model.sv]
// Behavioural model of the outside status groups and the output queue summaries.
`timescale 1ns/1ps
module sbs_groups_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       grp_clr,
  input  wire logic       load,
  input  wire logic [4:0] lvl,
  output logic            sum_oper,
  output logic            sum_ques,
  output logic            sum_hw2,
  output logic            sum_hw1,
  output logic            mav
);
  // ---------------------------------------------------------------------------
  // Summary levels
  // ---------------------------------------------------------------------------
  // The output queue is not an event group, so a clear leaves its summary alone.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {sum_oper, sum_ques, sum_hw2, sum_hw1, mav} <= 5'h00;
    end else if (load) begin
      {sum_oper, sum_ques, sum_hw2, sum_hw1, mav} <= lvl;
    end else if (grp_clr) begin
      {sum_oper, sum_ques, sum_hw2, sum_hw1} <= 4'h0;
    end
  end
endmodule

// [tb/sbs_status_top_bench.sv]
// Self-checking bench for the status byte and service request block.
`timescale 1ns/1ps
module sbs_status_top_bench;
  import sbs_pkg::*;
  // ---------------------------------------------------------------------------
  // Stimulus and observation
  // ---------------------------------------------------------------------------
  localparam int OPC = 0, CLS = 1, STANDARD_EVENT_FLAGS = 2, ESE = 3, ESW = 4, SRR = 5, SRW = 6, STB = 7, SPL = 8;
  logic             sys_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [8:0]       cmd = '0;
  logic             ops_idle = 1'b0;
  logic             load = 1'b0;
  logic [4:0]       lvl = '0;
  logic [4:0]       m_lvl;
  logic [SBS_W-1:0] wr_data = '0;
  logic [SBS_W-1:0] evt_set = '0;
  logic             sum_oper, sum_ques, sum_hw2, sum_hw1, mav;
  logic             rsp_valid_q, spoll_valid_q, srq_q, grp_clr_q, v, mss;
  logic [SBS_W-1:0] rsp_data_q, spoll_data_q, m_esr, m_ese, m_sre, d, sb;
  logic [31:0]      x;
  int               miscompares = 0;
  int               cmp_count = 0;
  int               seed = 32'h2df2;

  always #10 sys_clk = ~sys_clk;

  sbs_status_top u_sbs_status_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .cmd_opc(cmd[OPC]), .ops_idle(ops_idle), .cmd_cls(cmd[CLS]),
    .cmd_esr_rd(cmd[STANDARD_EVENT_FLAGS]), .cmd_ese_rd(cmd[ESE]), .cmd_ese_wr(cmd[ESW]), .cmd_sre_rd(cmd[SRR]),
    .cmd_sre_wr(cmd[SRW]), .cmd_stb_rd(cmd[STB]), .spoll_rd(cmd[SPL]), .wr_data(wr_data),
    .evt_set(evt_set), .sum_oper(sum_oper), .sum_ques(sum_ques), .sum_hw2(sum_hw2),
    .sum_hw1(sum_hw1), .mav(mav), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
    .spoll_valid_q(spoll_valid_q), .spoll_data_q(spoll_data_q), .srq_q(srq_q), .grp_clr_q(grp_clr_q)
  );

  sbs_groups_model u_sbs_groups_model (
    .sys_clk(sys_clk), .rst_n(rst_n), .grp_clr(grp_clr_q), .load(load), .lvl(lvl),
    .sum_oper(sum_oper), .sum_ques(sum_ques), .sum_hw2(sum_hw2), .sum_hw1(sum_hw1), .mav(mav)
  );

  // ---------------------------------------------------------------------------
  // Expectations, comparisons and bus cycles
  // ---------------------------------------------------------------------------
  // Order of the level vector: operation, questionable, hardware 2, hardware 1, message ready.
  function automatic logic [7:0] f_stb(input logic [4:0] l, input logic [7:0] e, input logic [7:0] en);
    return {l[4], 1'b0, |(e & en), l[0], l[3], 1'b0, l[2], l[1]};
  endfunction

  function automatic logic f_mss(input logic [7:0] s, input logic [7:0] r);
    return |(s & r & 8'hbf);
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // One command pulse; the answer stands in the cycle after the taking edge.
  task automatic ask(input int k, input logic [7:0] val);
    @(negedge sys_clk);
    wr_data = val;
    cmd[k] = 1'b1;
    @(negedge sys_clk);
    cmd = '0;
    v = (k == SPL) ? spoll_valid_q : ((k == CLS) ? grp_clr_q : rsp_valid_q);
    d = (k == SPL) ? spoll_data_q : rsp_data_q;
    if (k inside {STANDARD_EVENT_FLAGS, ESE, SRR, STB, SPL}) chk1(v, 1'b1);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    #200000;
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    wait_n(2);
    ask(STANDARD_EVENT_FLAGS, 8'h00);
    chk8(d, 8'h80);
    ask(STANDARD_EVENT_FLAGS, 8'h00);
    chk8(d, 8'h00);
    ask(OPC, 8'h00);
    wait_n(3);
    ask(STANDARD_EVENT_FLAGS, 8'h00);
    chk8(d, 8'h00);
    ops_idle = 1'b1;
    wait_n(2);
    ask(STANDARD_EVENT_FLAGS, 8'h00);
    chk8(d, 8'h01);
    ask(STANDARD_EVENT_FLAGS, 8'h00);
    chk8(d, 8'h00);
    ops_idle = 1'b0;
    ask(OPC, 8'h00);
    ask(CLS, 8'h00);
    ops_idle = 1'b1;
    wait_n(2);
    ask(STANDARD_EVENT_FLAGS, 8'h00);
    chk8(d, 8'h00);
    // Work already finished when the command arrives: the flag follows at once.
    ask(OPC, 8'h00);
    ask(STANDARD_EVENT_FLAGS, 8'h00);
    chk8(d, 8'h01);
    ops_idle = 1'b0;
    // Two queries in one cycle: only the event flags answer, and an event in the read cycle survives.
    evt_set = 8'h24;
    @(negedge sys_clk);
    evt_set = 8'h08;
    cmd[STANDARD_EVENT_FLAGS] = 1'b1;
    cmd[STB] = 1'b1;
    @(negedge sys_clk);
    cmd = '0;
    evt_set = 8'h00;
    chk8(rsp_data_q, 8'h24);
    ask(STANDARD_EVENT_FLAGS, 8'h00);
    chk8(d, 8'h08);
    for (int i = 0; i < 24; i++) begin
      ask(SRW, 8'h00);
      m_ese = (i % 4 == 0) ? 8'h00 : 8'($random(seed));
      ask(ESW, m_ese);
      x = $random(seed);
      lvl = x[4:0];
      m_lvl = x[4:0];
      evt_set = x[15:8];
      load = 1'b1;
      @(negedge sys_clk);
      load = 1'b0;
      evt_set = 8'h00;
      m_esr = x[15:8] & 8'hbe;
      m_sre = (i == 3) ? 8'h40 : 8'($random(seed));
      ask(SRW, m_sre);
      wait_n(3);
      sb = f_stb(m_lvl, m_esr, m_ese);
      mss = f_mss(sb, m_sre);
      chk1(srq_q, mss);
      ask(STB, 8'h00);
      chk8(d, sb | {1'b0, mss, 6'h00});
      ask(STB, 8'h00);
      chk8(d, sb | {1'b0, mss, 6'h00});
      ask(SRR, 8'h00);
      chk8(d, m_sre & 8'hbf);
      ask(ESE, 8'h00);
      chk8(d, m_ese);
      ask(SPL, 8'h00);
      chk8(d, sb | {1'b0, mss, 6'h00});
      ask(SPL, 8'h00);
      chk8(d, sb);
      chk1(srq_q, 1'b0);
      if (i % 2 == 1) begin
        ask(CLS, 8'h00);
        chk1(v, 1'b1);
        m_esr = 8'h00;
        m_lvl = m_lvl & 5'h01;
        wait_n(3);
        sb = f_stb(m_lvl, m_esr, m_ese);
        ask(STB, 8'h00);
        chk8(d, sb | {1'b0, f_mss(sb, m_sre), 6'h00});
      end
      ask(STANDARD_EVENT_FLAGS, 8'h00);
      chk8(d, m_esr);
    end
    conclude();
  end
endmodule
